// File: common/baud_gen_regs.svh
// Register addresses, field positions, reset values and divider counts of the baud generator
`ifndef BAUD_GEN_REGS_SVH
`define BAUD_GEN_REGS_SVH

`define ADDR_TIMER_CONTROL 8'h88
`define ADDR_TIMER_MODE 8'h89
`define ADDR_TIMER_LOW_BYTE 8'h8B
`define ADDR_RELOAD_HIGH_BYTE 8'h8D
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_SERIAL_CONTROL 8'h98

`define BAUD_DOUBLER_BIT 7
`define SERIAL_MODE_HI_BIT 7
`define SERIAL_MODE_LO_BIT 6
`define TIMER1_OVERFLOW_BIT 7
`define TIMER1_RUN_BIT 6
`define TIMER1_MODE_HI_BIT 5
`define TIMER1_MODE_LO_BIT 4

`define RESET_POWER_CONTROL 8'h00
`define RESET_SERIAL_CONTROL 8'h00
`define RESET_TIMER_CONTROL 8'h00
`define RESET_TIMER_MODE 8'h00
`define RESET_RELOAD_HIGH_BYTE 8'h00
`define RESET_TIMER_LOW_BYTE 8'h00
`define UNMAPPED_READ 8'h00

`define MACHINE_CYCLE_OSC 4'hC
`define RATE_SCALE_NORMAL 6'h20
`define RATE_SCALE_DOUBLED 6'h10

`endif

// File: common/baud_gen_pkg.sv
// Types shared by the baud generator and its reload timer
package baud_gen_pkg;

   typedef enum logic [1:0] {
      SHIFT_FIXED = 2'b00,
      UART8_VARIABLE = 2'b01,
      UART9_FIXED = 2'b10,
      UART9_VARIABLE = 2'b11
   } serial_mode_t;

   typedef enum logic [1:0] {
      TIMER_13BIT = 2'b00,
      TIMER_16BIT = 2'b01,
      TIMER_AUTO_RELOAD = 2'b10,
      TIMER_STOPPED = 2'b11
   } timer_mode_t;

endpackage

// File: common/timer_reload_if.sv
// Signals between the baud generator and its auto-reload timer
interface timer_reload_if;
   import baud_gen_pkg::*;

   logic count_tick;
   logic run;
   timer_mode_t mode;
   logic [7:0] reload_value;
   logic load_strobe;
   logic [7:0] load_value;
   logic [7:0] low_byte;
   logic overflow;

   modport timer (
      input count_tick,
      input run,
      input mode,
      input reload_value,
      input load_strobe,
      input load_value,
      output low_byte,
      output overflow
   );

   modport ctrl (
      output count_tick,
      output run,
      output mode,
      output reload_value,
      output load_strobe,
      output load_value,
      input low_byte,
      input overflow
   );
endinterface

// File: hw/reload_timer.sv
// Eight-bit auto-reload timer feeding the serial rate divider
`include "baud_gen_regs.svh"

module reload_timer (
   input wire logic core_clk,
   input wire logic reset_n,
   timer_reload_if.timer tmr
);
   import baud_gen_pkg::*;

   logic counting;
   logic wrap;

   assign counting = tmr.run && tmr.count_tick && (tmr.mode == TIMER_AUTO_RELOAD);
   assign wrap = counting && (tmr.low_byte == 8'hFF);

   // Low byte counts machine cycles and reloads on wrap
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tmr.low_byte <= `RESET_TIMER_LOW_BYTE;
      end
      else if (tmr.load_strobe)
      begin
         tmr.low_byte <= tmr.load_value;
      end
      else if (wrap)
      begin
         tmr.low_byte <= tmr.reload_value;
      end
      else if (counting)
      begin
         tmr.low_byte <= tmr.low_byte + 8'h01;
      end
   end

   // One pulse per wrap
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tmr.overflow <= 1'b0;
      end
      else
      begin
         tmr.overflow <= wrap && !tmr.load_strobe;
      end
   end
endmodule

// File: hw/serial_baud_rate_generator.sv
// Serial port bit-rate generator with its special function registers
`include "baud_gen_regs.svh"

// Contract
// - Mode 0 shifts at oscillator over twelve
// - Mode 1 rate comes from timer overflows
// - Timer rate is K*osc/(32*12*(256-reload))
// - K is 1, or 2 with doubler
// - Doubler is bit 7 at address 87H
// - Mode 2 is osc/32 doubled, osc/64 otherwise
// - Mode 2 uses phase-2 clock, no timer
// - Mode 3 rate set up like mode 1
// - Mode field decodes the four serial modes
// - Timer mode 10 is 8-bit auto-reload
module serial_baud_rate_generator (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   output logic baud_tick,
   output baud_gen_pkg::serial_mode_t serial_mode,
   output logic timer_overflow
);
   import baud_gen_pkg::*;

   logic [7:0] power_control_reg;
   logic [7:0] serial_control_reg;
   logic [7:0] timer_control_reg;
   logic [7:0] timer_mode_reg;
   logic [7:0] reload_high_byte_reg;
   logic [3:0] machine_cnt_reg;
   logic machine_tick;
   logic phase_reg;
   logic phase2_tick;
   logic [5:0] fixed_cnt_reg;
   logic [5:0] timer_div_reg;
   logic [5:0] scale_limit;
   logic baud_doubler;
   logic mode_write;
   serial_mode_t mode_next;
   logic baud_next;

   timer_reload_if tif ();

   // Scale for both the mode 2 divider and the timer divider
   function automatic logic [5:0] rate_scale(input logic doubler);
      if (doubler)
      begin
         return `RATE_SCALE_DOUBLED;
      end
      return `RATE_SCALE_NORMAL;
   endfunction

   // Serial mode field decode
   function automatic serial_mode_t decode_mode(input logic [7:0] ctrl);
      return serial_mode_t'({ctrl[`SERIAL_MODE_HI_BIT], ctrl[`SERIAL_MODE_LO_BIT]});
   endfunction

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction

   assign baud_doubler = power_control_reg[`BAUD_DOUBLER_BIT];
   assign scale_limit = rate_scale(baud_doubler);
   assign mode_write = sfr_wr && hit(sfr_addr, `ADDR_SERIAL_CONTROL);
   assign mode_next = decode_mode(serial_control_reg);

   // Byte-wide register writes
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         power_control_reg <= `RESET_POWER_CONTROL;
         serial_control_reg <= `RESET_SERIAL_CONTROL;
         timer_mode_reg <= `RESET_TIMER_MODE;
         reload_high_byte_reg <= `RESET_RELOAD_HIGH_BYTE;
      end
      else if (sfr_wr)
      begin
         if (hit(sfr_addr, `ADDR_POWER_CONTROL))
         begin
            power_control_reg <= sfr_wdata;
         end
         if (mode_write)
         begin
            serial_control_reg <= sfr_wdata;
         end
         if (hit(sfr_addr, `ADDR_TIMER_MODE))
         begin
            timer_mode_reg <= sfr_wdata;
         end
         if (hit(sfr_addr, `ADDR_RELOAD_HIGH_BYTE))
         begin
            reload_high_byte_reg <= sfr_wdata;
         end
      end
   end

   // Timer control; the overflow flag set wins over a write that clears it
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         timer_control_reg <= `RESET_TIMER_CONTROL;
      end
      else
      begin
         if (sfr_wr && hit(sfr_addr, `ADDR_TIMER_CONTROL))
         begin
            timer_control_reg <= sfr_wdata;
         end
         if (tif.overflow)
         begin
            timer_control_reg[`TIMER1_OVERFLOW_BIT] <= 1'b1;
         end
      end
   end

   // Machine cycle prescaler, one tick per twelve oscillator periods
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         machine_cnt_reg <= 4'h0;
      end
      else if (machine_cnt_reg == `MACHINE_CYCLE_OSC - 4'h1)
      begin
         machine_cnt_reg <= 4'h0;
      end
      else
      begin
         machine_cnt_reg <= machine_cnt_reg + 4'h1;
      end
   end

   assign machine_tick = (machine_cnt_reg == `MACHINE_CYCLE_OSC - 4'h1);

   // Internal phase-2 clock, one enable every second oscillator period
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= !phase_reg;
      end
   end

   assign phase2_tick = phase_reg;

   // Timer link
   assign tif.count_tick = machine_tick;
   assign tif.run = timer_control_reg[`TIMER1_RUN_BIT];
   assign tif.mode = timer_mode_t'({timer_mode_reg[`TIMER1_MODE_HI_BIT],
                                    timer_mode_reg[`TIMER1_MODE_LO_BIT]});
   assign tif.reload_value = reload_high_byte_reg;
   assign tif.load_strobe = sfr_wr && hit(sfr_addr, `ADDR_TIMER_LOW_BYTE);
   assign tif.load_value = sfr_wdata;

   reload_timer u_timer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .tmr(tif.timer)
   );

   // Mode 2 divider counts phase-2 enables
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fixed_cnt_reg <= 6'h00;
      end
      else if (mode_write)
      begin
         fixed_cnt_reg <= 6'h00;
      end
      else if (phase2_tick)
      begin
         if (fixed_cnt_reg >= scale_limit - 6'h01)
         begin
            fixed_cnt_reg <= 6'h00;
         end
         else
         begin
            fixed_cnt_reg <= fixed_cnt_reg + 6'h01;
         end
      end
   end

   // Timer-driven divider counts overflow pulses
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         timer_div_reg <= 6'h00;
      end
      else if (mode_write)
      begin
         timer_div_reg <= 6'h00;
      end
      else if (tif.overflow)
      begin
         if (timer_div_reg >= scale_limit - 6'h01)
         begin
            timer_div_reg <= 6'h00;
         end
         else
         begin
            timer_div_reg <= timer_div_reg + 6'h01;
         end
      end
   end

   // Rate source selection by serial mode
   always_comb
   begin
      case (serial_mode)
         SHIFT_FIXED:
         begin
            baud_next = machine_tick;
         end
         UART8_VARIABLE:
         begin
            baud_next = tif.overflow && (timer_div_reg >= scale_limit - 6'h01);
         end
         UART9_FIXED:
         begin
            baud_next = phase2_tick && (fixed_cnt_reg >= scale_limit - 6'h01);
         end
         UART9_VARIABLE:
         begin
            baud_next = tif.overflow && (timer_div_reg >= scale_limit - 6'h01);
         end
         default:
         begin
            baud_next = 1'b0;
         end
      endcase
   end

   // Registered outputs
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         serial_mode <= SHIFT_FIXED;
         baud_tick <= 1'b0;
         timer_overflow <= 1'b0;
      end
      else
      begin
         serial_mode <= mode_next;
         baud_tick <= baud_next && !mode_write;
         timer_overflow <= tif.overflow;
      end
   end

   // Registered read data, zero for unmapped addresses
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sfr_rdata <= `UNMAPPED_READ;
      end
      else if (sfr_rd)
      begin
         case (sfr_addr)
            `ADDR_POWER_CONTROL: sfr_rdata <= power_control_reg;
            `ADDR_SERIAL_CONTROL: sfr_rdata <= serial_control_reg;
            `ADDR_TIMER_CONTROL: sfr_rdata <= timer_control_reg;
            `ADDR_TIMER_MODE: sfr_rdata <= timer_mode_reg;
            `ADDR_TIMER_LOW_BYTE: sfr_rdata <= tif.low_byte;
            `ADDR_RELOAD_HIGH_BYTE: sfr_rdata <= reload_high_byte_reg;
            default: sfr_rdata <= `UNMAPPED_READ;
         endcase
      end
   end
endmodule

// File: verification/baud_gen_monitor.sv
// Port checker for the serial baud rate generator
`include "baud_gen_regs.svh"
module baud_gen_monitor (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic baud_tick,
   input wire baud_gen_pkg::serial_mode_t serial_mode,
   input wire logic timer_overflow
);
   timeunit 1ns;
   timeprecision 1ps;
   import baud_gen_pkg::*;
   logic [7:0] pc_reg, reload_reg;
   logic [1:0] tmode_reg;
   logic [5:0] ovf_cnt_reg;
   logic [15:0] age_reg, gap_reg, ovf_gap_reg;
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
      begin
         {pc_reg, reload_reg, tmode_reg, ovf_cnt_reg} <= '0;
         {age_reg, gap_reg, ovf_gap_reg} <= '0;
      end
      else
      begin
         if (sfr_wr && sfr_addr == `ADDR_POWER_CONTROL) pc_reg <= sfr_wdata;
         if (sfr_wr && sfr_addr == `ADDR_RELOAD_HIGH_BYTE) reload_reg <= sfr_wdata;
         if (sfr_wr && sfr_addr == `ADDR_TIMER_MODE) tmode_reg <= sfr_wdata[5:4];
         age_reg <= sfr_wr ? 16'h0000 : age_reg + 16'h0001;
         gap_reg <= baud_tick ? 16'h0000 : gap_reg + 16'h0001;
         ovf_gap_reg <= timer_overflow ? 16'h0000 : ovf_gap_reg + 16'h0001;
         ovf_cnt_reg <= (baud_tick ? 6'h00 : ovf_cnt_reg) + {5'h00, timer_overflow};
      end
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   sequence sc_write;
      sfr_wr && sfr_addr == `ADDR_SERIAL_CONTROL;
   endsequence
   fixed_rate_a: assert property (
      baud_tick && !serial_mode[0] && age_reg > 16'h0064 |->
      gap_reg == (serial_mode[1] ? (pc_reg[7] ? 16'h001F : 16'h003F) : 16'h000B))
      else $error("fixed bit time wrong");
   var_rate_a: assert property (
      baud_tick && serial_mode[0] && age_reg > 16'h0400 |->
      ovf_cnt_reg == (pc_reg[7] ? 6'h10 : 6'h20)) else $error("variable bit time wrong");
   ovf_rate_a: assert property (
      timer_overflow && age_reg > 16'h0200 |->
      ovf_gap_reg == 16'h000C * (16'h0100 - {8'h00, reload_reg}) - 16'h0001)
      else $error("overflow spacing wrong");
   timer_hold_a: assert property (
      age_reg > 16'h0002 && tmode_reg != 2'h2 |-> !timer_overflow)
      else $error("overflow while held");
   mode_follow_a: assert property (
      sc_write |-> ##2 serial_mode == $past(sfr_wdata[7:6], 2)) else $error("mode wrong");
   pc_read_a: assert property (
      sfr_rd && sfr_addr == `ADDR_POWER_CONTROL |=> sfr_rdata == $past(pc_reg))
      else $error("readback wrong");
   tick_pulse_a: assert property (
      baud_tick |=> !baud_tick) else $error("tick too long");
   ovf_pulse_a: assert property (
      timer_overflow |=> !timer_overflow) else $error("overflow too long");
endmodule
bind serial_baud_rate_generator baud_gen_monitor mon (.core_clk(core_clk),
   .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
   .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .baud_tick(baud_tick),
   .serial_mode(serial_mode), .timer_overflow(timer_overflow));

// File: verification/framing_model.sv
// Framing-side model measuring the bit time it is clocked with
module framing_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic baud_tick,
   output logic [15:0] period_reg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] gap_reg;
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
      begin
         gap_reg <= 16'h0000;
         period_reg <= 16'h0000;
      end
      else
      begin
         gap_reg <= baud_tick ? 16'h0000 : gap_reg + 16'h0001;
         if (baud_tick) period_reg <= gap_reg + 16'h0001;
      end
endmodule

// File: verification/tb_serial_baud_rate_generator.sv
// Testbench for the serial baud rate generator
`include "baud_gen_regs.svh"
module tb_serial_baud_rate_generator;
   timeunit 1ns;
   timeprecision 1ps;
   import baud_gen_pkg::*;
   logic core_clk, reset_n, sfr_wr, sfr_rd, baud_tick, timer_overflow;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
   serial_mode_t serial_mode;
   logic [15:0] period_reg;
   int errors, compares, cycles, ovf_seen, ovf_mark;
   // Serial control, power control, reload byte, bit time in cycles
   logic [39:0] cases [7] = '{40'h0000FF000C, 40'h8080FF0020, 40'h8000FF0040,
      40'h4000FF0180, 40'h4080FF00C0, 40'hC080FE0180, 40'hC000FE0300};
   serial_baud_rate_generator dut (.core_clk(core_clk), .reset_n(reset_n),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .baud_tick(baud_tick), .serial_mode(serial_mode),
      .timer_overflow(timer_overflow));
   framing_model far_end (.core_clk(core_clk), .reset_n(reset_n), .baud_tick(baud_tick),
      .period_reg(period_reg));
   always #5 core_clk = ~core_clk;
   task automatic test_done();
      if (errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cycles++;
      if (timer_overflow === 1'b1) ovf_seen++;
      if (cycles == 40000)
      begin
         errors++;
         test_done();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge core_clk);
      sfr_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge core_clk);
      sfr_rd <= 1'b0;
      @(posedge core_clk);
      v = sfr_rdata;
   endtask
   initial
   begin
      {core_clk, reset_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(`ADDR_SERIAL_CONTROL);
      check({8'h00, v}, 16'h0000);
      rd(`ADDR_POWER_CONTROL);
      check({8'h00, v}, 16'h0000);
      wr(`ADDR_POWER_CONTROL, v | 8'h80);
      rd(`ADDR_POWER_CONTROL);
      check({8'h00, v}, 16'h0080);
      wr(`ADDR_TIMER_MODE, 8'h20);
      wr(`ADDR_TIMER_LOW_BYTE, 8'hFF);
      wr(`ADDR_TIMER_CONTROL, 8'h40);
      foreach (cases[i])
      begin
         wr(`ADDR_RELOAD_HIGH_BYTE, cases[i][23:16]);
         wr(`ADDR_POWER_CONTROL, cases[i][31:24]);
         wr(`ADDR_SERIAL_CONTROL, cases[i][39:32]);
         repeat (8 * cases[i][15:0] + 120) @(posedge core_clk);
         check(period_reg, cases[i][15:0]);
         check({14'h0000, serial_mode}, {14'h0000, cases[i][39:38]});
      end
      // Overflow flag set by the timer, run bit still set
      rd(`ADDR_TIMER_CONTROL);
      check({8'h00, v}, 16'h00C0);
      wr(`ADDR_TIMER_MODE, 8'h00);
      wr(`ADDR_SERIAL_CONTROL, 8'h80);
      ovf_mark = ovf_seen;
      repeat (600) @(posedge core_clk);
      check(period_reg, 16'h0040);
      check(16'(ovf_seen - ovf_mark), 16'h0000);
      test_done();
   end
endmodule
